/* logic/sgc_defs.vh */
// constants for the secondary clock gating block: offsets, fields, resets, codes
// assumes the includer works in byte offsets of configuration space
`ifndef SGC_DEFS_VH
`define SGC_DEFS_VH

// byte offsets in configuration space
`define SGC_OFS_GEN_CTRL 8'hD4
`define SGC_OFS_CLK_DISABLE 8'hD8
`define SGC_OFS_CLK_MASK 8'hD9
`define SGC_OFS_CLK_RUN_STATE 8'hDA

// general control fields
`define SGC_POLICY_HI 22
`define SGC_POLICY_LO 20
`define SGC_SCALE_HI 9
`define SGC_SCALE_LO 8
`define SGC_VALUE_HI 7
`define SGC_VALUE_LO 0

// reset values
`define SGC_RST_POLICY 3'h0
`define SGC_RST_SCALE 2'h2
`define SGC_RST_VALUE 8'h5F
`define SGC_RST_CLK_BITS 7'h00

// power limit policy codes
`define SGC_POL_IGNORE 3'h0
`define SGC_POL_PIN 3'h1
`define SGC_POL_SHED 3'h2
`define SGC_POL_SHED_PIN 3'h3

// power scale multipliers, in milliwatt steps per unit of value
`define SGC_MW_SCALE0 18'h003E8
`define SGC_MW_SCALE1 18'h00064
`define SGC_MW_SCALE2 18'h0000A
`define SGC_MW_SCALE3 18'h00001

// secondary clock half period in clk cycles
`define SGC_HALF_PERIOD 2

`endif

/* logic/sgc_clock_gate.v */
// one gated secondary clock output, built from a shared half-period tick
// assumes tick pulses one cycle each half period, all outputs share it
`timescale 1ns/1ns
module sgc_clock_gate (
    input wire clk,
    input wire rst_n,
    input wire tick,
    input wire run,
    output reg clock_out,
    output reg stopped
);

    // run is only sampled at a rising-edge decision point, so a high phase is never cut short
    always @(posedge clk) begin
        if (!rst_n) begin
            clock_out <= 1'b0;
            stopped <= 1'b0;
        end else if (tick) begin
            if (clock_out) begin
                clock_out <= 1'b0; // always finish the high half
            end else begin
                clock_out <= run;
                stopped <= ~run;
            end
        end
    end

endmodule

/* logic/sgc_secondary_clock_gating.v */
// secondary clock gating: config registers, power limit check, seven gated clock outputs
// assumes a simple config port synchronous to clk and slot power limit inputs from the link layer
`timescale 1ns/1ns
`include "sgc_defs.vh"
module sgc_secondary_clock_gating #(
    parameter NUM_OUT = 7,
    parameter HALF_PERIOD = `SGC_HALF_PERIOD
) (
    input wire clk,
    input wire reset_n,
    input wire link_reset_n,
    input wire global_reset_in_n,
    input wire [7:0] cfg_addr,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [3:0] cfg_be,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata,
    output reg cfg_rvalid,
    input wire [7:0] slot_limit_value,
    input wire [1:0] slot_limit_scale,
    output wire [NUM_OUT-1:0] secondary_clock_output,
    output reg power_limit_violation_pin
);

    // scale a value/scale pair to milliwatts; shared by the slot limit and the bridge need
    // the largest product, 255 x 1000, still fits the 18-bit result
    function [17:0] to_mw;
        input [7:0] value;
        input [1:0] scale;
        reg [17:0] mult;
        begin
            case (scale)
                2'h0: mult = `SGC_MW_SCALE0;
                2'h1: mult = `SGC_MW_SCALE1;
                2'h2: mult = `SGC_MW_SCALE2;
                default: mult = `SGC_MW_SCALE3;
            endcase
            to_mw = mult * {10'h000, value};
        end
    endfunction

    // the three reset sources act alike on every register here
    // one edge of any of them is enough, since nothing in this block is sticky
    wire rst_n = reset_n & link_reset_n & global_reset_in_n;

    reg [2:0] policy;
    reg [1:0] min_scale;
    reg [7:0] min_value;
    reg [NUM_OUT-1:0] out_stop;
    reg [NUM_OUT-1:0] out_shed;
    reg violation;
    wire [NUM_OUT-1:0] gate_stopped;

    // byte offsets held as vectors so that their dword index can be sliced
    localparam [7:0] OFS_GEN = `SGC_OFS_GEN_CTRL;
    localparam [7:0] OFS_CLK = `SGC_OFS_CLK_DISABLE;

    // dword match of a byte offset; the two low address bits pick a lane, not a register
    function dword_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            dword_hit = (addr[7:2] == ofs[7:2]);
        end
    endfunction

    // dword decode of the byte offset; the mask and run state bytes are lanes of the disable dword
    wire hit_gen = dword_hit(cfg_addr, OFS_GEN);
    wire hit_clk = dword_hit(cfg_addr, OFS_CLK);

    // general control fields; other bits of that dword belong elsewhere and read zero here
    // reserved policy codes are stored as written and read back, but act like 000
    always @(posedge clk) begin
        if (!rst_n) begin
            policy <= `SGC_RST_POLICY;
            min_scale <= `SGC_RST_SCALE;
            min_value <= `SGC_RST_VALUE;
        end else if (cfg_wr && hit_gen) begin
            if (cfg_be[0]) begin
                min_value <= cfg_wdata[`SGC_VALUE_HI:`SGC_VALUE_LO];
            end
            if (cfg_be[1]) begin
                min_scale <= cfg_wdata[`SGC_SCALE_HI:`SGC_SCALE_LO];
            end
            if (cfg_be[2]) begin
                policy <= cfg_wdata[`SGC_POLICY_HI:`SGC_POLICY_LO];
            end
        end
    end

    // disable in byte 0 and mask in byte 1; bit 7 of each is never stored
    // the run state byte is read-only, so byte lane 2 is ignored on writes
    always @(posedge clk) begin
        if (!rst_n) begin
            out_stop <= `SGC_RST_CLK_BITS;
            out_shed <= `SGC_RST_CLK_BITS;
        end else if (cfg_wr && hit_clk) begin
            if (cfg_be[0]) begin
                out_stop <= cfg_wdata[NUM_OUT-1:0];
            end
            if (cfg_be[1]) begin
                out_shed <= cfg_wdata[8+NUM_OUT-1:8];
            end
        end
    end

    // required power against slot limit; registered to keep the multiply off the gating path
    // a limit exactly equal to the need is not a violation
    wire [17:0] need_mw = to_mw(min_value, min_scale);
    wire [17:0] limit_mw = to_mw(slot_limit_value, slot_limit_scale);
    always @(posedge clk) begin
        if (!rst_n) begin
            violation <= 1'b0;
        end else begin
            violation <= (limit_mw < need_mw);
        end
    end

    // policy codes that let the mask stop clocks; 000, 001 and the reserved codes do nothing here
    function sheds_clocks;
        input [2:0] code;
        begin
            sheds_clocks = (code == `SGC_POL_SHED) || (code == `SGC_POL_SHED_PIN);
        end
    endfunction

    // policy codes that drive the violation pin
    function raises_pin;
        input [2:0] code;
        begin
            raises_pin = (code == `SGC_POL_PIN) || (code == `SGC_POL_SHED_PIN);
        end
    endfunction

    // only the two shedding policies let the mask act
    wire shed_policy = sheds_clocks(policy);
    wire shed_active = shed_policy & violation;
    wire [NUM_OUT-1:0] run = ~(out_stop | (out_shed & {NUM_OUT{shed_active}}));

    // the pin follows the violation only for the pin-raising policies
    always @(posedge clk) begin
        if (!rst_n) begin
            power_limit_violation_pin <= 1'b0;
        end else begin
            power_limit_violation_pin <= violation && raises_pin(policy);
        end
    end

    // shared half-period tick; one divider keeps all output edges on the same ticks, though an output restarted alone can run in antiphase
    // the terminal count is cut to the 8-bit divider on purpose, so HALF_PERIOD stays below 257
    localparam [31:0] TICK_AT_FULL = HALF_PERIOD - 1;
    localparam [7:0] TICK_AT = TICK_AT_FULL[7:0];
    reg [7:0] div_count;
    wire tick = (div_count == TICK_AT);
    always @(posedge clk) begin
        if (!rst_n) begin
            div_count <= 8'h00;
        end else if (tick) begin
            div_count <= 8'h00;
        end else begin
            div_count <= div_count + 8'h01;
        end
    end

    // one gate per output
    // each gate waits for its own low phase before it stops or restarts
    genvar i;
    generate
        for (i = 0; i < NUM_OUT; i = i + 1) begin : g_out
            sgc_clock_gate u_gate (
                .clk(clk),
                .rst_n(rst_n),
                .tick(tick),
                .run(run[i]),
                .clock_out(secondary_clock_output[i]),
                .stopped(gate_stopped[i])
            );
        end
    endgenerate

    // status reports stopped only once every output has really halted
    // limitation: a bus with only some outputs gated still reads as running
    wire all_stopped = &gate_stopped;

    // read data registered one cycle after the strobe; unmapped dwords read zero
    // a write and a read in one cycle return the value from before the write
    reg [31:0] next_rdata;
    always @* begin
        next_rdata = 32'h00000000;
        if (hit_gen) begin
            next_rdata[`SGC_POLICY_HI:`SGC_POLICY_LO] = policy;
            next_rdata[`SGC_SCALE_HI:`SGC_SCALE_LO] = min_scale;
            next_rdata[`SGC_VALUE_HI:`SGC_VALUE_LO] = min_value;
        end else if (hit_clk) begin
            next_rdata[NUM_OUT-1:0] = out_stop; // bit 7 stays zero
            next_rdata[8+NUM_OUT-1:8] = out_shed; // bit 15 stays zero
            next_rdata[16] = all_stopped; // bits 23:17 zero
        end
    end

    // rvalid answers every read strobe, mapped or not, exactly one cycle later
    always @(posedge clk) begin
        if (!rst_n) begin
            cfg_rdata <= 32'h00000000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

endmodule

/* testbench/sgc_gating_sva.sv */
// assertions on the ports of the gating block
// assumes a bind onto the top module
`timescale 1ns/1ns
module sgc_gating_sva #(parameter NUM_OUT = 7, parameter HALF_PERIOD = 2) (
    input wire clk,
    input wire reset_n,
    input wire link_reset_n,
    input wire global_reset_in_n,
    input wire [7:0] cfg_addr,
    input wire cfg_rd,
    input wire [31:0] cfg_rdata,
    input wire cfg_rvalid,
    input wire [NUM_OUT-1:0] secondary_clock_output,
    input wire power_limit_violation_pin
);
    // any one of the three resets clears the block
    wire ok = reset_n & link_reset_n & global_reset_in_n;
    default clocking @(posedge clk); endclocking
    default disable iff (!ok);
    property p_rv; cfg_rd |=> cfg_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read answer late");
    property p_rv1; !cfg_rd |=> !cfg_rvalid; endproperty
    a_rv1: assert property (p_rv1) else $error("stray read answer");
    // read data only moves at an answer; the edge right after a reset clear is left out
    property p_hold; !cfg_rvalid && $past(ok) |-> $stable(cfg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_d8;
        cfg_rvalid && $past(cfg_addr[7:2]) == 6'h36 |->
            cfg_rdata[31:17] == 15'h0000 && !cfg_rdata[15] && !cfg_rdata[7];
    endproperty
    a_d8: assert property (p_d8) else $error("reserved bit set");
    property p_st;
        cfg_rvalid && $past(cfg_addr[7:2]) == 6'h36 && cfg_rdata[16] |->
            secondary_clock_output == {NUM_OUT{1'b0}};
    endproperty
    a_st: assert property (p_st) else $error("stopped but running");
    property p_d4;
        cfg_rvalid && $past(cfg_addr[7:2]) == 6'h35 |->
            cfg_rdata[31:23] == 9'h000 && cfg_rdata[19:10] == 10'h000;
    endproperty
    a_d4: assert property (p_d4) else $error("control spare bit set");
    property p_hi;
        $rose(secondary_clock_output[0]) |=>
            secondary_clock_output[0] && !$fell(secondary_clock_output[0]);
    endproperty
    a_hi: assert property (p_hi) else $error("short high phase");
    property p_rst; $rose(ok) |-> secondary_clock_output == 0 && !power_limit_violation_pin; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule

/* testbench/sgc_pci_load.sv */
// pci devices on the secondary clocks, each counting its rising edges
// assumes the clocks come straight from the gating block
`timescale 1ns/1ns
module sgc_pci_load (
    input wire [6:0] pci_clk,
    output wire [6:0][15:0] edges
);
    // edge count per device shows whether its clock really runs
    for (genvar i = 0; i < 7; i++) begin : g_dev
        logic [15:0] count = 16'h0000;
        always @(posedge pci_clk[i]) count <= count + 16'h0001;
        assign edges[i] = count;
    end
endmodule

/* testbench/sgc_secondary_clock_gating_tb.sv */
// self-checking bench for the secondary clock gating block
// assumes the design, checker and device model compiled before it
`timescale 1ns/1ns
module sgc_secondary_clock_gating_tb;
    logic clk = 0, reset_n = 0, link_reset_n = 1, global_reset_in_n = 1, cfg_wr = 0, cfg_rd = 0;
    logic [7:0] cfg_addr = 8'h00, slot_limit_value = 8'h00;
    logic [1:0] slot_limit_scale = 2'h0;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h00000000, cfg_rdata, seed = 32'hEE94BACA;
    logic cfg_rvalid, power_limit_violation_pin;
    logic [6:0] secondary_clock_output;
    wire [6:0][15:0] edges;
    logic [15:0] n0;
    logic [31:0] notes [$];
    int fails = 0, checked = 0, cycles = 0;
    sgc_secondary_clock_gating i_sgc_secondary_clock_gating (
        .clk(clk),
        .reset_n(reset_n),
        .link_reset_n(link_reset_n),
        .global_reset_in_n(global_reset_in_n),
        .cfg_addr(cfg_addr),
        .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd),
        .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid),
        .slot_limit_value(slot_limit_value),
        .slot_limit_scale(slot_limit_scale),
        .secondary_clock_output(secondary_clock_output),
        .power_limit_violation_pin(power_limit_violation_pin)
    );
    sgc_pci_load i_sgc_pci_load (.pci_clk(secondary_clock_output), .edges(edges));
    always #5 clk = ~clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic finish_test();
        // a note left over means an answer never came
        if (notes.size() != 0) fails++;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle strobe, entered and left at a falling edge, then one idle cycle
    // so that a following call never raises the strobe in the step that lowered it
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {w, !w, a, b, d};
        @(negedge clk);
        {cfg_wr, cfg_rd} = 2'b00;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        notes.push_back(exp);
        acc(0, a, 4'hF, 32'h00000000);
    endtask
    // gating settles within two half periods plus two cycles
    task automatic settle();
        repeat (12) @(negedge clk);
    endtask
    // answers are matched against the oldest note; the timeout sits last
    always @(negedge clk) begin
        cycles++;
        if (cfg_rvalid === 1'b1) check(cfg_rdata, notes.pop_front());
        if (cycles == 3000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        reset_n = 1;
        rd(8'hD4, 32'h0000025F);
        rd(8'hD8, 32'h00000000);
        acc(1, 8'hD8, 4'h7, 32'hFFFFFFFF);
        settle();
        rd(8'hD8, 32'h00017F7F);
        n0 = edges[3];
        settle();
        check(32'(secondary_clock_output), 32'h00000000);
        check(32'(edges[3]), 32'(n0));
        // mask alone under the ignore policy must not stop anything
        acc(1, 8'hD8, 4'h1, 32'h00000000);
        settle();
        check(32'(edges[3] != n0), 32'h00000001);
        for (int p = 0; p < 8; p++) begin
            acc(1, 8'hD4, 4'h4, 32'(p) << 20);
            settle();
            check(32'(power_limit_violation_pin), 32'(p == 1 || p == 3));
            rd(8'hD8, {15'h0000, p == 2 || p == 3, 16'h7F00});
        end
        // enough slot power, random and exactly equal, leaves clocks running
        acc(1, 8'hD4, 4'h4, 32'h00200000);
        for (int k = 0; k < 4; k++) begin
            {slot_limit_scale, slot_limit_value} = k == 3 ? 10'h25F : {2'h0, 8'(xs()) | 8'h01};
            settle();
            rd(8'hD8, 32'h00007F00);
        end
        acc(1, 8'hD4, 4'h1, 32'h000000C8);
        settle();
        rd(8'hD4, 32'h002002C8);
        rd(8'hD8, 32'h00017F00);
        acc(1, 8'hD4, 4'h2, 32'h00000300);
        settle();
        rd(8'hD8, 32'h00007F00);
        // scale code 01 lifts the need to 20 W, far above the slot limit
        acc(1, 8'hD4, 4'h2, 32'h00000100);
        settle();
        rd(8'hD8, 32'h00017F00);
        acc(1, 8'hE0, 4'hF, 32'hFFFFFFFF);
        rd(8'hE0, 32'h00000000);
        for (int r = 0; r < 2; r++) begin
            acc(1, 8'hD8, 4'h3, 32'h00007F7F);
            {link_reset_n, global_reset_in_n} = r ? 2'b10 : 2'b01;
            @(negedge clk);
            {link_reset_n, global_reset_in_n} = 2'b11;
            rd(8'hD8, 32'h00000000);
        end
        settle();
        finish_test();
    end
endmodule
bind sgc_secondary_clock_gating sgc_gating_sva #(
    .NUM_OUT(NUM_OUT),
    .HALF_PERIOD(HALF_PERIOD)
) i_sgc_gating_sva (
    .clk(clk),
    .reset_n(reset_n),
    .link_reset_n(link_reset_n),
    .global_reset_in_n(global_reset_in_n),
    .cfg_addr(cfg_addr),
    .cfg_rd(cfg_rd),
    .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid),
    .secondary_clock_output(secondary_clock_output),
    .power_limit_violation_pin(power_limit_violation_pin)
);
